// ===== fwd_lookup_pkg.sv
// constants and types for the forwarding lookup control block
package fwd_lookup_pkg;

  // register offsets (byte registers)
  localparam logic [7:0] DA_OFS        = 8'h0A;
  localparam int         DA_BYTES      = 6;
  localparam logic [7:0] CALC_STAT_OFS = 8'h10;
  localparam logic [7:0] KEY_LO_OFS    = 8'h11;
  localparam logic [7:0] KEY_HI_OFS    = 8'h12;
  localparam logic [7:0] MISS_EN_LO    = 8'h13;
  localparam logic [7:0] MISS_EN_HI    = 8'h14;
  localparam logic [7:0] MISS_CNT_LO   = 8'h15;
  localparam logic [7:0] MISS_CNT_HI   = 8'h16;
  localparam logic [7:0] CONF_CNT_LO   = 8'h17;
  localparam logic [7:0] CONF_CNT_HI   = 8'h18;
  localparam logic [7:0] UC_MASK_LO    = 8'h19;
  localparam logic [7:0] UC_MASK_HI    = 8'h1A;
  localparam logic [7:0] MC_MASK_LO    = 8'h1B;
  localparam logic [7:0] MC_MASK_HI    = 8'h1C;
  localparam logic [7:0] OVR_SEL_OFS   = 8'h1D;
  localparam logic [7:0] OVR_LO_OFS    = 8'h1E;
  localparam logic [7:0] OVR_HI_OFS    = 8'h1F;
  localparam logic [7:0] SPECIAL_OFS   = 8'h20;
  localparam logic [7:0] FWD_CFG_OFS   = 8'h21;
  localparam logic [7:0] DROP_LO_OFS   = 8'h22;
  localparam logic [7:0] DROP_HI_OFS   = 8'h23;

  // widths and ports
  localparam int         PORTS    = 10;
  localparam int         OVR_W    = 9;
  localparam int         KEY_W    = 11;
  localparam int         TAG_W    = 39;
  localparam int         TAG_LSB  = 9;
  localparam logic [3:0] PORT_CPU = 4'h8;
  localparam logic [3:0] PORT_MII = 4'h9;

  // reset values
  localparam logic [9:0] MISS_EN_RST = 10'h1FF;
  localparam logic [9:0] UC_MASK_RST = 10'h1FF;
  localparam logic [9:0] MC_MASK_RST = 10'h1FF;

  // fixed masks and frame classes
  localparam logic [9:0]  CPU_BIT      = 10'h100;
  localparam logic [9:0]  ALL_PORTS    = 10'h3FF;
  localparam logic [47:0] BCAST_ADDR   = 48'hFFFF_FFFF_FFFF;
  localparam logic [47:0] STP_ADDR     = 48'h0180_C200_0000;
  localparam logic [43:0] RES_MC_HEAD  = 44'h0180_C200_000;
  localparam logic [3:0]  RES_MC_FIRST = 4'h2;

  // hash calculation: serial crc over the 48 address bits
  localparam logic [10:0] CRC11_POLY  = 11'h0385;
  localparam logic [5:0]  CALC_CYCLES = 6'h30;

  typedef enum logic {CALC_IDLE, CALC_RUN} calc_state_t;

  typedef struct packed {
    logic [3:0]  src_port;
    logic [47:0] dest;
    logic        hit;
    logic [9:0]  hit_mask;
  } lookup_req_t;

  typedef struct packed {
    logic [9:0] dest_mask;
    logic       override_used;
    logic       dropped;
  } lookup_res_t;

  typedef struct packed {
    calc_state_t  calc;
    logic [5:0]   calc_cnt;
    logic [47:0]  da;
    logic [47:0]  shift;
    logic [10:0]  crc;
    logic [10:0]  key;
    logic [38:0]  tag;
    logic [9:0]   miss_en;
    logic [15:0]  miss_cnt;
    logic [7:0]   miss_hi;
    logic [15:0]  conf_cnt;
    logic [7:0]   conf_hi;
    logic [9:0]   uc_mask;
    logic [9:0]   mc_mask;
    logic         ovr_sel;
    logic [8:0]   ovr;
    logic [7:0]   special;
    logic [3:0]   fwd_cfg;
    logic [7:0]   rdata;
    logic         res_valid;
    lookup_res_t  res;
  } state_t;

endpackage

// ===== forwarding_lookup_control.sv
// forwarding lookup control and status registers
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module forwarding_lookup_control
  import fwd_lookup_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  // register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // lookup request from the lookup engine
  input  wire logic              lk_valid_i,
  input  wire lookup_req_t       lk_req_i,
  input  wire logic [47:0]       own_addr_i,
  input  wire logic              hash_conflict_i,
  // congestion status from transmit logic
  input  wire logic [8:0]        drop_on_i,
  input  wire logic [9:0]        port_congested_i,
  // forwarding result
  output logic                   fwd_valid_o,
  output lookup_res_t            fwd_res_o,
  // hash calculation result
  output logic                   hash_calc_busy_o,
  output logic [10:0]            hash_key_o,
  output logic [38:0]            hash_tag_o
);

  state_t s_q;
  state_t s_d;

  // per-port congestion hit between a mask and the congested ports
  logic [9:0] cong_hit;
  logic [9:0] pre_mask;

  genvar g;
  generate
    for (g = 0; g < PORTS; g++)
    begin : g_cong
      assign cong_hit[g] = pre_mask[g] & port_congested_i[g];
    end
  endgenerate

  // frame classification of the requested destination
  logic [9:0] src_bit;
  logic       is_bcast;
  logic       is_mcast;
  logic       is_stp;
  logic       is_res_mc;
  logic       is_own;
  logic       ovr_hit;
  logic       drop_src;

  always_comb
  begin
    src_bit   = 10'(1) << lk_req_i.src_port;
    is_bcast  = lk_req_i.dest == BCAST_ADDR;
    is_mcast  = lk_req_i.dest[40];
    is_stp    = lk_req_i.dest == STP_ADDR;
    is_res_mc = (lk_req_i.dest[47:4] == RES_MC_HEAD)
                && (lk_req_i.dest[3:0] >= RES_MC_FIRST);
    is_own    = !is_mcast && (lk_req_i.dest == own_addr_i);
    ovr_hit   = (s_q.ovr != '0) && (lk_req_i.src_port ==
                (s_q.ovr_sel ? PORT_MII : PORT_CPU));
    drop_src  = (lk_req_i.src_port < PORT_MII)
                && drop_on_i[lk_req_i.src_port[3:0]];
  end

  // forwarding decision before congestion drop
  logic count_miss;

  always_comb
  begin
    pre_mask   = '0;
    count_miss = 1'b0;
    if (ovr_hit)
    begin
      pre_mask = {1'b0, s_q.ovr};
    end
    else if (is_bcast && lk_req_i.src_port == PORT_CPU && s_q.special[0])
    begin
      pre_mask = '0;
    end
    else if (is_stp)
    begin
      if (s_q.fwd_cfg[1])
        pre_mask = CPU_BIT;
      else
        pre_mask = ALL_PORTS & ~src_bit;
    end
    else if (is_res_mc)
    begin
      pre_mask = s_q.fwd_cfg[3] ? CPU_BIT : '0;
    end
    else if (is_own && s_q.fwd_cfg[2])
    begin
      pre_mask = CPU_BIT;
    end
    else if (is_bcast)
    begin
      pre_mask = ALL_PORTS & ~CPU_BIT & ~src_bit;
      if (s_q.fwd_cfg[0])
        pre_mask = pre_mask | CPU_BIT;
    end
    else if (lk_req_i.hit)
    begin
      pre_mask = lk_req_i.hit_mask;
    end
    else
    begin
      pre_mask   = is_mcast ? s_q.mc_mask : s_q.uc_mask;
      count_miss = |(s_q.miss_en & src_bit);
    end
  end

  // next state
  logic       miss_clr;
  logic       conf_clr;
  logic       miss_inc;

  always_comb
  begin
    s_d      = s_q;
    miss_clr = reg_rd_i && reg_addr_i == MISS_CNT_LO;
    conf_clr = reg_rd_i && reg_addr_i == CONF_CNT_LO;
    miss_inc = lk_valid_i && count_miss;

    // lookup result, registered
    s_d.res_valid         = lk_valid_i;
    s_d.res.override_used = lk_valid_i && ovr_hit;
    s_d.res.dropped       = lk_valid_i && drop_src && |cong_hit;
    s_d.res.dest_mask     = '0;
    if (lk_valid_i)
    begin
      s_d.res.dest_mask = (drop_src && |cong_hit) ? '0 : pre_mask;
      if (ovr_hit)
        s_d.ovr = '0;
    end

    // hash calculation sequencer
    unique case (s_q.calc)
      CALC_IDLE:
      begin
        s_d.calc_cnt = '0;
      end
      CALC_RUN:
      begin
        s_d.shift    = {s_q.shift[46:0], 1'b0};
        s_d.crc      = {s_q.crc[9:0], 1'b0}
                       ^ ((s_q.crc[10] ^ s_q.shift[47]) ? CRC11_POLY : '0);
        s_d.calc_cnt = s_q.calc_cnt + 6'(1);
        if (s_q.calc_cnt == CALC_CYCLES - 6'(1))
        begin
          s_d.calc = CALC_IDLE;
          s_d.key  = s_d.crc;
        end
      end
    endcase

    // statistics counters: clear on read, set wins, saturate
    if (miss_clr)
      s_d.miss_cnt = '0;
    if (miss_inc && s_d.miss_cnt != '1)
      s_d.miss_cnt = s_d.miss_cnt + 16'(1);
    if (conf_clr)
      s_d.conf_cnt = '0;
    if (hash_conflict_i && s_d.conf_cnt != '1)
      s_d.conf_cnt = s_d.conf_cnt + 16'(1);

    // register read, data in the following cycle
    s_d.rdata = '0;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        CALC_STAT_OFS: s_d.rdata = {7'h00, s_q.calc == CALC_RUN};
        KEY_LO_OFS:    s_d.rdata = s_q.key[7:0];
        KEY_HI_OFS:    s_d.rdata = {5'h00, s_q.key[10:8]};
        MISS_EN_LO:    s_d.rdata = s_q.miss_en[7:0];
        MISS_EN_HI:    s_d.rdata = {6'h00, s_q.miss_en[9:8]};
        MISS_CNT_LO:
        begin
          s_d.rdata   = s_q.miss_cnt[7:0];
          s_d.miss_hi = s_q.miss_cnt[15:8];
        end
        MISS_CNT_HI:   s_d.rdata = s_q.miss_hi;
        CONF_CNT_LO:
        begin
          s_d.rdata   = s_q.conf_cnt[7:0];
          s_d.conf_hi = s_q.conf_cnt[15:8];
        end
        CONF_CNT_HI:   s_d.rdata = s_q.conf_hi;
        UC_MASK_LO:    s_d.rdata = s_q.uc_mask[7:0];
        UC_MASK_HI:    s_d.rdata = {6'h00, s_q.uc_mask[9:8]};
        MC_MASK_LO:    s_d.rdata = s_q.mc_mask[7:0];
        MC_MASK_HI:    s_d.rdata = {6'h00, s_q.mc_mask[9:8]};
        OVR_SEL_OFS:   s_d.rdata = {7'h00, s_q.ovr_sel};
        OVR_LO_OFS:    s_d.rdata = s_q.ovr[7:0];
        OVR_HI_OFS:    s_d.rdata = {7'h00, s_q.ovr[8]};
        SPECIAL_OFS:   s_d.rdata = s_q.special;
        FWD_CFG_OFS:   s_d.rdata = {4'h0, s_q.fwd_cfg};
        DROP_LO_OFS:   s_d.rdata = drop_on_i[7:0];
        DROP_HI_OFS:   s_d.rdata = {7'h00, drop_on_i[8]};
        default:
        begin
          for (int k = 0; k < DA_BYTES; k++)
          begin
            if (reg_addr_i == DA_OFS + 8'(k))
              s_d.rdata = s_q.da[47 - 8 * k -: 8];
          end
        end
      endcase
    end

    // register write; a write to the override mask beats its self-clear
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        MISS_EN_LO:  s_d.miss_en[7:0] = reg_wdata_i;
        MISS_EN_HI:  s_d.miss_en[9:8] = reg_wdata_i[1:0];
        UC_MASK_LO:  s_d.uc_mask[7:0] = reg_wdata_i;
        UC_MASK_HI:  s_d.uc_mask[9:8] = reg_wdata_i[1:0];
        MC_MASK_LO:  s_d.mc_mask[7:0] = reg_wdata_i;
        MC_MASK_HI:  s_d.mc_mask[9:8] = reg_wdata_i[1:0];
        OVR_SEL_OFS: s_d.ovr_sel = reg_wdata_i[0];
        OVR_LO_OFS:  s_d.ovr[7:0] = reg_wdata_i;
        OVR_HI_OFS:  s_d.ovr[8] = reg_wdata_i[0];
        SPECIAL_OFS: s_d.special = reg_wdata_i;
        FWD_CFG_OFS: s_d.fwd_cfg = reg_wdata_i[3:0];
        default:
        begin
          for (int k = 0; k < DA_BYTES; k++)
          begin
            if (reg_addr_i == DA_OFS + 8'(k))
            begin
              s_d.da[47 - 8 * k -: 8] = reg_wdata_i;
              s_d.calc                = CALC_RUN;
              s_d.calc_cnt            = '0;
              s_d.crc                 = '0;
            end
          end
          if (reg_addr_i >= DA_OFS && reg_addr_i < DA_OFS + 8'(DA_BYTES))
          begin
            s_d.shift = s_d.da;
            s_d.tag   = s_d.da[47:TAG_LSB];
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_q         <= '0;
      s_q.calc    <= CALC_IDLE;
      s_q.miss_en <= MISS_EN_RST;
      s_q.uc_mask <= UC_MASK_RST;
      s_q.mc_mask <= MC_MASK_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o      = s_q.rdata;
  assign fwd_valid_o      = s_q.res_valid;
  assign fwd_res_o        = s_q.res;
  assign hash_calc_busy_o = s_q.calc == CALC_RUN;
  assign hash_key_o       = s_q.key;
  assign hash_tag_o       = s_q.tag;

endmodule

`default_nettype wire

// ===== fwd_lookup_chk.sv
// assertion checker for the forwarding lookup control block
`timescale 1ns/100ps
`default_nettype none
module fwd_lookup_chk
  import fwd_lookup_pkg::*;
(
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  // register port
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  // lookup side
  input wire logic        lk_valid_i,
  input wire lookup_req_t lk_req_i,
  input wire logic [8:0]  drop_on_i,
  input wire logic        fwd_valid_o,
  input wire lookup_res_t fwd_res_o,
  input wire logic        hash_calc_busy_o
);
  logic [5:0] cnt_q;
  wire logic  da_wr = reg_wr_i && reg_addr_i >= DA_OFS && reg_addr_i <= 8'h0f;

  // cycles since the last address write, stops at its top
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_q <= 6'h00;
    else if (da_wr)
      cnt_q <= 6'h01;
    else if (cnt_q != 6'h00 && cnt_q != 6'h3f)
      cnt_q <= cnt_q + 6'h01;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_busy_start: assert property (da_wr |=> hash_calc_busy_o)
    else $error("busy not raised after address write");
  a_busy_len: assert property ($fell(hash_calc_busy_o) |-> cnt_q inside {[6'h30:6'h32]})
    else $error("hash calculation length wrong");
  a_busy_read: assert property (reg_rd_i && reg_addr_i == CALC_STAT_OFS
    |=> reg_rdata_o == {7'h00, $past(hash_calc_busy_o)})
    else $error("busy readback differs from busy output");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read");
  a_fwd_pulse: assert property (fwd_valid_o == $past(lk_valid_i))
    else $error("forward result not one cycle after request");
  a_ovr_mask: assert property (fwd_res_o.override_used |-> fwd_valid_o
    && fwd_res_o.dest_mask[9] == 1'b0
    && (fwd_res_o.dropped || fwd_res_o.dest_mask != 10'h000))
    else $error("override result mask malformed");
  a_ovr_once: assert property (fwd_res_o.override_used && !$past(reg_wr_i)
    |=> !fwd_res_o.override_used)
    else $error("override mask used twice");
  a_drop_zero: assert property (fwd_res_o.dropped |-> fwd_res_o.dest_mask == 10'h000
    && $past(drop_on_i[lk_req_i.src_port]))
    else $error("drop without zero mask or drop enable");

  c_override: cover property (fwd_res_o.override_used);
  c_drop: cover property (fwd_res_o.dropped);
  c_calc_done: cover property ($fell(hash_calc_busy_o));
endmodule

bind forwarding_lookup_control fwd_lookup_chk u_chk (.mclk_i, .rstn_i, .reg_addr_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .lk_valid_i, .lk_req_i, .drop_on_i, .fwd_valid_o, .fwd_res_o,
  .hash_calc_busy_o);
`default_nettype wire

// ===== forwarding_lookup_control_tb_top.sv
// self-checking testbench for the forwarding lookup control block
`timescale 1ns/100ps
`default_nettype none
module forwarding_lookup_control_tb_top
  import fwd_lookup_pkg::*;
;
  localparam logic [47:0] UC = 48'h0200_0000_0001;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic        lk_valid_i = 1'b0;
  lookup_req_t lk_req_i = '0;
  logic [47:0] own_addr_i = 48'h0200_0000_00aa;
  logic        hash_conflict_i = 1'b0;
  logic [8:0]  drop_on_i = 9'h000;
  logic [9:0]  port_congested_i = 10'h000;
  logic        fwd_valid_o;
  lookup_res_t fwd_res_o;
  logic        hash_calc_busy_o;
  logic [10:0] hash_key_o;
  logic [38:0] hash_tag_o;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [7:0]  rv;
  logic [10:0] key;
  logic [47:0] da = 48'h0180_c2a5_5a3c;
  logic [15:0] ra[9] = '{16'h13ff, 16'h1401, 16'h19ff, 16'h1a01, 16'h1bff, 16'h1c01,
                         16'h2100, 16'h1e00, 16'h4000};
  logic [47:0] dl[4] = '{BCAST_ADDR, STP_ADDR, 48'h0180_c200_0005, 48'h0200_0000_00aa};
  logic [9:0]  ex[8] = '{10'h2fb, 10'h3fb, 10'h000, 10'h20f,
                         10'h3fb, 10'h100, 10'h100, 10'h100};

  always #4 mclk_i = ~mclk_i;

  forwarding_lookup_control DUT (.mclk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .lk_valid_i, .lk_req_i, .own_addr_i, .hash_conflict_i,
    .drop_on_i, .port_congested_i, .fwd_valid_o, .fwd_res_o, .hash_calc_busy_o,
    .hash_key_o, .hash_tag_o);

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    rv = reg_rdata_o;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, e);
  endtask

  // one lookup; e is dest mask, override flag, drop flag
  task automatic lk(input logic [3:0] s, input logic [47:0] d, input logic [9:0] h,
                    input logic [11:0] e);
    @(posedge mclk_i);
    lk_valid_i <= 1'b1;
    lk_req_i <= '{s, d, h != 10'h000, h};
    @(posedge mclk_i);
    lk_valid_i <= 1'b0;
    @(negedge mclk_i);
    chk({fwd_valid_o, fwd_res_o}, {1'b1, e});
  endtask

  // serial crc, msb first
  function automatic logic [10:0] crc(input logic [47:0] d);
    logic [10:0] c;
    c = 11'h000;
    for (int i = 47; i >= 0; i--)
      c = {c[9:0], 1'b0} ^ ((c[10] ^ d[i]) ? CRC11_POLY : 11'h000);
    return c;
  endfunction

  initial
  begin
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    foreach (ra[i])
      rc(ra[i][15:8], ra[i][7:0]);
    for (int i = 0; i < 6; i++)
      wr(DA_OFS + 8'(i), da[47 - 8 * i -: 8]);
    rc(CALC_STAT_OFS, 8'h01);
    for (int n = 0; n < 100 && rv !== 8'h00; n++)
      rd(CALC_STAT_OFS);
    chk(rv, 8'h00);
    if (rv !== 8'h00)
      close_out;
    key = crc(da);
    rc(KEY_LO_OFS, key[7:0]);
    rc(KEY_HI_OFS, {5'h00, key[10:8]});
    chk(hash_tag_o, da[47:9]);
    chk(hash_key_o, key);
    wr(UC_MASK_LO, 8'h0f);
    wr(UC_MASK_HI, 8'h02);
    lk(4'h0, UC, 10'h000, {10'h20f, 2'b00});
    lk(4'h1, 48'h0100_0000_0001, 10'h000, {10'h1ff, 2'b00});
    wr(MISS_EN_LO, 8'hfb);
    lk(4'h2, UC, 10'h000, {10'h20f, 2'b00});
    lk(4'h3, UC, 10'h0f0, {10'h0f0, 2'b00});
    wr(OVR_LO_OFS, 8'h05);
    lk(4'h8, UC, 10'h000, {10'h005, 2'b10});
    lk(4'h8, UC, 10'h000, {10'h20f, 2'b00});
    rc(OVR_LO_OFS, 8'h00);
    wr(OVR_SEL_OFS, 8'h01);
    wr(OVR_LO_OFS, 8'h03);
    lk(4'h8, UC, 10'h000, {10'h20f, 2'b00});
    lk(4'h9, UC, 10'h000, {10'h003, 2'b10});
    rc(MISS_CNT_LO, 8'h04);
    rc(MISS_CNT_HI, 8'h00);
    rc(MISS_CNT_LO, 8'h00);
    for (int c = 0; c < 2; c++)
    begin
      wr(FWD_CFG_OFS, c ? 8'h0f : 8'h00);
      for (int k = 0; k < 4; k++)
        lk(4'h2, dl[k], 10'h000, {ex[4 * c + k], 2'b00});
    end
    lk(4'h8, BCAST_ADDR, 10'h000, {10'h3ff, 2'b00});
    wr(SPECIAL_OFS, 8'h01);
    lk(4'h8, BCAST_ADDR, 10'h000, {10'h000, 2'b00});
    @(posedge mclk_i);
    drop_on_i <= 9'h001;
    port_congested_i <= 10'h010;
    lk(4'h0, UC, 10'h030, {10'h000, 2'b01});
    lk(4'h0, UC, 10'h020, {10'h020, 2'b00});
    lk(4'h1, UC, 10'h010, {10'h010, 2'b00});
    wr(DROP_LO_OFS, 8'h00);
    rc(DROP_LO_OFS, 8'h01);
    @(posedge mclk_i);
    hash_conflict_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    hash_conflict_i <= 1'b0;
    rc(CONF_CNT_LO, 8'h03);
    rc(CONF_CNT_HI, 8'h00);
    rc(CONF_CNT_LO, 8'h00);
    // a conflict in the clearing read cycle must survive the clear
    @(posedge mclk_i);
    reg_addr_i <= CONF_CNT_LO;
    reg_rd_i <= 1'b1;
    hash_conflict_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    hash_conflict_i <= 1'b0;
    @(negedge mclk_i);
    chk(reg_rdata_o, 8'h00);
    rc(CONF_CNT_LO, 8'h01);
    close_out;
  end
endmodule
`default_nettype wire
